// >>> logic/dfir_top.sv
// Operation
// - one-bit samples in, 16-bit words out
// - sample input at half the clock rate
// - one output word per 128 samples
// - each word convolves latest 384 samples
// - three accumulators share one 384-word store
// - accumulators staggered 128 samples apart
// - one multiply-accumulate per accumulator per sample, no delay line
// - linear phase through symmetric weights
`timescale 1ns/10ps
`include "dfir_map.svh"
module dfir_top (
  input  wire logic            clk,
  input  wire logic            resetn,
  input  wire logic            en,
  input  wire logic            modBit,
  input  wire logic            wordReady,
  output logic                 modClk,
  output logic                 sampleAccept,
  output dfir_pkg::dfir_word_t wordOut,
  output logic                 wordValid
);
  import dfir_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // which third of its convolution accumulator k is in
  function automatic dfir_seg_t relSeg(dfir_seg_t seg, int unsigned k);
    logic [2:0] s;
    s = {1'b0, seg} + 3'(`DFIR_NACC) - 3'(k);
    if (s >= 3'(`DFIR_NACC)) begin
      s = s - 3'(`DFIR_NACC);
    end
    return s[1:0];
  endfunction

  // rel * 128 + phase
  function automatic dfir_addr_t coefAddr(dfir_seg_t rel, dfir_phase_t ph);
    return {rel, ph};
  endfunction

  // one-bit input turns the multiply into add or subtract
  function automatic dfir_acc_t stepAcc(dfir_acc_t acc, dfir_coef_t c, logic b,
                                        logic clr);
    dfir_acc_t base;
    dfir_acc_t w;
    base = clr ? '0 : acc;
    w    = dfir_acc_t'({1'b0, c});
    return b ? base + w : base - w;
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic        tick_q;
  logic        modClk_q;
  logic        accept_q;
  dfir_phase_t phase_q;
  dfir_seg_t   seg_q;
  dfir_acc_t   acc_q [`DFIR_NACC];
  logic [2:0]  started_q;
  dfir_word_t  res_q;
  logic        resValid_q;
  dfir_word_t  wordOut_q;
  logic        wordValid_q;
  logic [8:0]  stepCnt0_q;

  logic        stall;
  logic        sampleEv;
  dfir_seg_t   rel [`DFIR_NACC];
  dfir_addr_t  addr [`DFIR_NACC];
  dfir_coef_t  coef [`DFIR_NACC];
  dfir_acc_t   accNext [`DFIR_NACC];
  logic [2:0]  startK;
  logic [2:0]  doneK;
  dfir_acc_t   finished;

  dfir_stream_if pushIf ();
  dfir_stream_if popIf ();

  assign modClk       = modClk_q;
  assign sampleAccept = accept_q;
  assign wordOut      = wordOut_q;
  assign wordValid    = wordValid_q;

  // ----------------------------------------------------------------
  // sample timing
  // ----------------------------------------------------------------
  // a finished word that the fifo cannot take holds the sampler back;
  // the modulator is not stallable, so the held samples are skipped
  assign stall    = resValid_q && !pushIf.ready;
  assign sampleEv = en && tick_q && !stall;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_q   <= 1'b0;
      modClk_q <= 1'b0;
      accept_q <= 1'b0;
    end else if (en) begin
      tick_q   <= !tick_q;
      modClk_q <= tick_q;
      accept_q <= !stall;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= '0;
      seg_q   <= '0;
    end else if (sampleEv) begin
      phase_q <= phase_q + 1'b1;
      if (phase_q == `DFIR_LAST_PHASE) begin
        seg_q <= (seg_q == `DFIR_LAST_SEG) ? '0 : seg_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // shared coefficient store
  // ----------------------------------------------------------------
  // staggered addresses into one store
  always_comb begin
    for (int k = 0; k < `DFIR_NACC; k++) begin
      rel[k]  = relSeg(seg_q, k);
      addr[k] = coefAddr(rel[k], phase_q);
    end
  end

  dfir_coef_rom u_rom (
    .clk    (clk),
    .resetn (resetn),
    .addr   (addr),
    .coef   (coef)
  );

  // ----------------------------------------------------------------
  // accumulators
  // ----------------------------------------------------------------
  // clear on start, sign from bit
  always_comb begin
    finished = '0;
    for (int k = 0; k < `DFIR_NACC; k++) begin
      startK[k]  = (rel[k] == '0) && (phase_q == '0);
      doneK[k]   = (rel[k] == `DFIR_LAST_SEG) && (phase_q == `DFIR_LAST_PHASE)
                   && started_q[k];
      accNext[k] = stepAcc(acc_q[k], coef[k], modBit, startK[k]);
      if (doneK[k]) begin
        finished = accNext[k];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < `DFIR_NACC; k++) begin
        acc_q[k] <= '0;
      end
      started_q <= '0;
    end else if (sampleEv) begin
      for (int k = 0; k < `DFIR_NACC; k++) begin
        acc_q[k] <= accNext[k];
      end
      // words from a convolution begun before reset would be partial
      started_q <= started_q | startK;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      res_q      <= '0;
      resValid_q <= 1'b0;
    end else if (en) begin
      if (sampleEv && (doneK != '0)) begin
        res_q      <= dfir_word_t'(finished >>> `DFIR_OUT_SHIFT);
        resValid_q <= 1'b1;
      end else if (pushIf.ready) begin
        resValid_q <= 1'b0;
      end
    end
  end

  // step counter for accumulator 0, only checked below
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stepCnt0_q <= '0;
    end else if (sampleEv) begin
      stepCnt0_q <= startK[0] ? 9'h001 : stepCnt0_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // output buffer and register
  // ----------------------------------------------------------------
  assign pushIf.valid = resValid_q;
  assign pushIf.data  = res_q;
  assign popIf.ready  = en && (!wordValid_q || wordReady);

  dfir_fifo #(
    .WIDTH (`DFIR_OUT_W),
    .DEPTH (`DFIR_FIFO_DEPTH)
  ) u_fifo (
    .clk    (clk),
    .resetn (resetn),
    .en     (en),
    .wrSide (pushIf.snk),
    .rdSide (popIf.src)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wordOut_q   <= '0;
      wordValid_q <= 1'b0;
    end else if (en) begin
      if (popIf.valid && popIf.ready) begin
        wordOut_q   <= popIf.data;
        wordValid_q <= 1'b1;
      end else if (wordReady) begin
        wordValid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_SAMPLE_HALF_RATE: assert property (
    @(posedge clk) disable iff (!resetn)
    sampleEv |=> !sampleEv)
    else $error("two samples in adjacent cycles");

  AST_MODCLK_FOLLOWS: assert property (
    @(posedge clk) disable iff (!resetn)
    en |=> modClk == $past(tick_q))
    else $error("modulator clock not half rate");

  AST_PHASE_WRAP: assert property (
    @(posedge clk) disable iff (!resetn)
    (sampleEv && phase_q == `DFIR_LAST_PHASE) |=> (phase_q == '0))
    else $error("phase did not wrap after 128 samples");

  AST_DONE_ONLY_AT_END: assert property (
    @(posedge clk) disable iff (!resetn)
    (doneK != '0) |-> (phase_q == `DFIR_LAST_PHASE))
    else $error("completion away from block end");

  AST_ONE_FINISHER: assert property (
    @(posedge clk) disable iff (!resetn)
    $onehot0(doneK))
    else $error("more than one accumulator finished");

  AST_ADDR_STAGGER: assert property (
    @(posedge clk) disable iff (!resetn)
    (addr[1] - addr[0] == 9'h100 || addr[0] - addr[1] == 9'h080)
    && addr[0][6:0] == phase_q && addr[2][6:0] == phase_q)
    else $error("accumulator addresses not 128 apart");

  AST_FULL_SPAN: assert property (
    @(posedge clk) disable iff (!resetn)
    (sampleEv && doneK[0]) |-> (stepCnt0_q == 9'h17F))
    else $error("convolution not 384 samples long");

  AST_START_CLEARS: assert property (
    @(posedge clk) disable iff (!resetn)
    (sampleEv && startK[0]) |=>
    acc_q[0] == ($past(modBit) ? dfir_acc_t'({1'b0, $past(coef[0])})
                               : -dfir_acc_t'({1'b0, $past(coef[0])})))
    else $error("accumulator not cleared at start");

  AST_HOLD_BETWEEN: assert property (
    @(posedge clk) disable iff (!resetn)
    !sampleEv |=> $stable(acc_q[1]))
    else $error("accumulator moved without a sample");

  AST_WORD_SCALED: assert property (
    @(posedge clk) disable iff (!resetn)
    (sampleEv && doneK != '0) |=>
    resValid_q && res_q == dfir_word_t'($past(finished) >>> `DFIR_OUT_SHIFT))
    else $error("output word wrongly formed");

  AST_WORD_HOLDS: assert property (
    @(posedge clk) disable iff (!resetn)
    (wordValid && !wordReady) |=> (wordValid && $stable(wordOut)))
    else $error("output word dropped before it was taken");

  AST_ACCEPT_TRACKS: assert property (
    @(posedge clk) disable iff (!resetn)
    en |=> (sampleAccept == !$past(stall)))
    else $error("sample accept flag out of step with the sampler");

  COV_ACC0_DONE: cover property (@(posedge clk) disable iff (!resetn)
    sampleEv && doneK[0]);
  COV_ACC2_DONE: cover property (@(posedge clk) disable iff (!resetn)
    sampleEv && doneK[2]);
  COV_STALL: cover property (@(posedge clk) disable iff (!resetn)
    en && stall);
  COV_WORD_TAKEN: cover property (@(posedge clk) disable iff (!resetn)
    wordValid && wordReady);

endmodule

// >>> logic/dfir_map.svh
`ifndef DFIR_MAP_SVH
`define DFIR_MAP_SVH

// ----------------------------------------------------------------
// filter geometry
// ----------------------------------------------------------------
`define DFIR_TAPS        384
`define DFIR_DECIM       128
`define DFIR_NACC        3
`define DFIR_PHASE_W     7
`define DFIR_SEG_W       2
`define DFIR_ADDR_W      9
`define DFIR_COEF_W      8
`define DFIR_ACC_W       18
`define DFIR_OUT_W       16
`define DFIR_OUT_SHIFT   1
`define DFIR_LAST_PHASE  7'h7F
`define DFIR_LAST_SEG    2'h2

// ----------------------------------------------------------------
// clocking and buffering
// ----------------------------------------------------------------
`define DFIR_CLK_MHZ     50
`define DFIR_MOD_DIV     2
`define DFIR_FIFO_DEPTH  8

`endif

// >>> logic/dfir_pkg.sv
package dfir_pkg;
`include "dfir_map.svh"

  typedef logic [`DFIR_ADDR_W-1:0]         dfir_addr_t;
  typedef logic [`DFIR_COEF_W-1:0]         dfir_coef_t;
  typedef logic signed [`DFIR_ACC_W-1:0]   dfir_acc_t;
  typedef logic [`DFIR_OUT_W-1:0]          dfir_word_t;
  typedef logic [`DFIR_PHASE_W-1:0]        dfir_phase_t;
  typedef logic [`DFIR_SEG_W-1:0]          dfir_seg_t;

endpackage

// >>> logic/dfir_stream_if.sv
`timescale 1ns/10ps
interface dfir_stream_if;
  import dfir_pkg::*;
  logic       valid;
  logic       ready;
  dfir_word_t data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> logic/dfir_coef_rom.sv
`timescale 1ns/10ps
`include "dfir_map.svh"
module dfir_coef_rom (
  input  wire logic           clk,
  input  wire logic           resetn,
  input  dfir_pkg::dfir_addr_t addr [`DFIR_NACC],
  output dfir_pkg::dfir_coef_t coef [`DFIR_NACC]
);
  import dfir_pkg::*;

  // ----------------------------------------------------------------
  // shared coefficient store
  // ----------------------------------------------------------------
  // mirrored weights
  // a symmetric triangle keeps the response linear phase
  function automatic dfir_coef_t coefFor(int unsigned i);
    int unsigned v;
    v = (i < `DFIR_TAPS / 2) ? i + 1 : `DFIR_TAPS - i;
    return dfir_coef_t'(v);
  endfunction

  dfir_coef_t mem [`DFIR_TAPS];

  for (genvar i = 0; i < `DFIR_TAPS; i++) begin : g_fill
    assign mem[i] = coefFor(i);
  end

  // three read ports, one per accumulator, all on the same array
  for (genvar k = 0; k < `DFIR_NACC; k++) begin : g_port
    assign coef[k] = mem[addr[k]];
  end

  AST_COEF_SYMMETRIC: assert property (
    @(posedge clk) disable iff (!resetn)
    coef[0] == mem[dfir_addr_t'(`DFIR_TAPS - 1) - addr[0]])
    else $error("coefficient set not symmetric");

endmodule

// >>> logic/dfir_fifo.sv
`timescale 1ns/10ps
`include "dfir_map.svh"
module dfir_fifo #(
  parameter int WIDTH = `DFIR_OUT_W,
  parameter int DEPTH = `DFIR_FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        en,
  dfir_stream_if.snk       wrSide,
  dfir_stream_if.src       rdSide
);
  import dfir_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_q;
  logic [PTR_W-1:0] rdPtr_q;
  logic [CNT_W-1:0] count_q;
  logic             push;
  logic             pop;

  assign wrSide.ready = (count_q != CNT_W'(DEPTH));
  assign rdSide.valid = (count_q != '0);
  assign rdSide.data  = dfir_word_t'(mem[rdPtr_q]);
  assign push         = en && wrSide.valid && wrSide.ready;
  assign pop          = en && rdSide.valid && rdSide.ready;

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= WIDTH'(wrSide.data);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// >>> tb/dfir_mod_model.sv
`timescale 1ns/10ps
module dfir_mod_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        en,
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] pos,
  input  wire logic        hold,
  output logic             modBit,
  output logic             wordReady
);
  int   idx_q;
  logic tick_q;

  // ----------------------------------------------------------------
  // bit source: constant, alternating or a single impulse
  // ----------------------------------------------------------------
  function automatic logic bit_at(int n);
    case (mode)
      2'h0: return 1'b0;
      2'h1: return 1'b1;
      2'h2: return n[0];
      default: return n == int'(pos);
    endcase
  endfunction

  // a modulator cannot wait, so it moves on every second enabled edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idx_q <= 0;
      tick_q <= 1'b0;
      modBit <= bit_at(0);
      wordReady <= 1'b0;
    end else begin
      wordReady <= !hold;
      if (en) begin
        tick_q <= !tick_q;
        if (tick_q) begin
          idx_q <= idx_q + 1;
          modBit <= bit_at(idx_q + 1);
        end
      end
    end
  end
endmodule

// >>> tb/decimating_fir_filter_tb.sv
`timescale 1ns/10ps
module decimating_fir_filter_tb;
  import dfir_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        en = 1'b0;
  logic        hold = 1'b1;
  logic [1:0]  mode = 2'h0;
  logic [15:0] pos = 16'h0000;
  logic        modBit;
  logic        wordReady;
  logic        modClk;
  logic        sampleAccept;
  logic        wordValid;
  dfir_word_t  wordOut;
  int          errors = 0;
  int          samplesChecked = 0;
  int          cyc = 0;
  dfir_word_t  got[$];
  int          at[$];

  always #10 clk = ~clk;

  dfir_top dfir_top_inst (.clk(clk), .resetn(resetn), .en(en), .modBit(modBit),
    .wordReady(wordReady), .modClk(modClk), .sampleAccept(sampleAccept),
    .wordOut(wordOut), .wordValid(wordValid));
  dfir_mod_model dfir_mod_model_inst (.clk(clk), .resetn(resetn), .en(en), .mode(mode),
    .pos(pos), .hold(hold), .modBit(modBit), .wordReady(wordReady));

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wordValid === 1'b1 && wordReady === 1'b1) begin
      got.push_back(wordOut);
      at.push_back(cyc);
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(string what, logic [15:0] exp, logic [15:0] seen);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic restart(logic [1:0] m, logic [15:0] p);
    @(posedge clk);
    resetn <= 1'b0;
    mode <= m;
    pos <= p;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    en <= 1'b1;
    got.delete();
    at.delete();
  endtask

  task automatic wait_words(int n);
    int w;
    w = 0;
    while (got.size() < n && w < 5000) begin
      @(posedge clk);
      w++;
    end
    check("word count", 16'(n), 16'(got.size()));
  endtask

  // triangle weights, bits taken from the source's own sequence
  function automatic dfir_word_t exp_word(int k);
    dfir_acc_t s;
    int        c;
    s = '0;
    for (int i = 0; i < 384; i++) begin
      c = (i < 192) ? i + 1 : 384 - i;
      s = dfir_mod_model_inst.bit_at(128 * k + i) ? s + c : s - c;
    end
    return dfir_word_t'(s >>> 1);
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_rate;
    logic prev;
    restart(2'h1, 16'h0000);
    hold <= 1'b0;
    @(posedge clk);
    #1 prev = modClk;
    repeat (10) begin
      @(posedge clk);
      #1 check("modClk", {15'h0000, ~prev}, {15'h0000, modClk});
      prev = modClk;
    end
    wait_words(3);
    for (int k = 0; k < 3; k++) begin
      check("wordOut", 16'h4860, got[k]);
    end
    check("spacing", 16'h0100, 16'(at[1] - at[0]));
    check("spacing", 16'h0100, 16'(at[2] - at[1]));
    $display("test_rate done");
  endtask

  task automatic test_impulse;
    int p[3] = '{0, 300, 383};
    foreach (p[j]) begin
      restart(2'h3, 16'(p[j]));
      hold <= 1'b0;
      wait_words(3);
      // impulse at 300 or 383 seen by all three overlapping words, at 0 by word 0 only
      for (int k = 0; k < 3; k++) begin
        check("wordOut", exp_word(k), got[k]);
      end
    end
    $display("test_impulse done");
  endtask

  task automatic test_patterns;
    for (int m = 0; m < 3; m++) begin
      restart(2'(m), 16'h0000);
      hold <= 1'b0;
      wait_words(2);
      // signed add or subtract per bit
      check("wordOut", exp_word(0), got[0]);
      check("wordOut", exp_word(1), got[1]);
    end
    $display("test_patterns done");
  endtask

  task automatic test_stall;
    int         lowSeen;
    logic       keep;
    lowSeen = 0;
    restart(2'h1, 16'h0000);
    hold <= 1'b1;
    repeat (100) @(posedge clk);
    repeat (3500) begin
      @(posedge clk);
      if (sampleAccept === 1'b0) lowSeen++;
    end
    check("stalled", 16'h0001, 16'(lowSeen != 0));
    check("taken", 16'h0000, 16'(got.size()));
    en <= 1'b0;
    @(posedge clk);
    #1 keep = modClk;
    repeat (40) @(posedge clk);
    #1 check("frozen", {15'h0000, keep}, {15'h0000, modClk});
    @(posedge clk);
    en <= 1'b1;
    hold <= 1'b0;
    wait_words(10);
    for (int k = 0; k < 10; k++) begin
      check("wordOut", 16'h4860, got[k]);
    end
    $display("test_stall done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    wrap_up();
  end

  initial begin
    test_rate();
    test_impulse();
    test_patterns();
    test_stall();
    wrap_up();
  end
endmodule
